// ===== hw/adsq_pkg.sv
// Constants and types shared by the dual-sample conversion sequencer.
// Overview of operation
// - Pairing mode converts one pair A0/B0..A7/B7.
// - Pulse module, software or pin trigger starts.
// - Each pairing-mode hold pulse converts both pair channels.
// - Flags rise a few cycles after result.
// - Pair captured together at hold falling edge.
// - Hold pulse lasts one plus window converter clocks.
// - Sampling starts 2.5 converter clocks after trigger.
// - First A result after 4, B after 5.
// - Later same-group results spaced three plus window in pairing mode.
// - Pairing off converts one channel per pulse.
// - Sixteen inputs, twelve-bit results, ten-stage pipeline.
package adsq_pkg;
  localparam int SYS_CLK_NS      = 40;
  localparam int CONV_CLK_NS     = 80;
  localparam int CONV_DIV        = CONV_CLK_NS / SYS_CLK_NS;
  localparam int SH_DELAY_HALVES = 5;
  localparam int SH_DELAY_TICKS  = (SH_DELAY_HALVES * CONV_DIV) / 2;
  localparam int RES_A_CLKS      = 4;
  localparam int RES_B_CLKS      = 5;
  localparam int GAP_PAIR_CLKS   = 2;
  localparam int GAP_SEQ_CLKS    = 1;
  localparam int FLAG_DELAY      = 2;
  localparam int RES_A_TAP       = RES_A_CLKS * CONV_DIV - 1;
  localparam int RES_B_TAP       = RES_B_CLKS * CONV_DIV - 1;
  localparam int PIPE_DEPTH      = RES_B_CLKS * CONV_DIV;
  localparam int ACQ_LSB         = 8;
  localparam int ACQ_W           = 4;
  localparam int CHAN_W          = 4;
  localparam int DATA_W          = 12;
  localparam int CNT_W           = 8;
  localparam logic [CHAN_W-1:0] CHAN_RESET = 4'h0;
  localparam logic [DATA_W-1:0] DATA_RESET = 12'h000;
  localparam logic [ACQ_W-1:0]  ACQ_RESET  = 4'h0;

  typedef enum logic [1:0] {
    ADSQ_IDLE,
    ADSQ_DELAY,
    ADSQ_HOLD,
    ADSQ_GAP
  } adsq_state_e;
endpackage

// ===== hw/adsq_sequencer.sv
// Trigger, sample/hold timing, pair capture and result sequencing for the converter.
`timescale 1ns/10ps
module adsq_sequencer
  import adsq_pkg::*;
#(
  parameter int DATA_WIDTH = DATA_W
) (
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  input  wire logic                  sample_pairing_select,
  input  wire logic [15:0]           converter_control_one,
  input  wire logic [CHAN_W-1:0]     chan_select,
  input  wire logic                  continuous_run,
  input  wire logic                  pulse_width_module_trigger,
  input  wire logic                  software_trigger,
  input  wire logic                  external_conversion_trigger,
  input  wire logic [DATA_WIDTH-1:0] analog_a_value,
  input  wire logic [DATA_WIDTH-1:0] analog_b_value,
  output logic                       converter_clock,
  output logic                       sample_hold_pulse,
  output logic [CHAN_W-1:0]          chan_a_q,
  output logic [CHAN_W-1:0]          chan_b_q,
  output logic [DATA_WIDTH-1:0]      result_a_q,
  output logic [DATA_WIDTH-1:0]      result_b_q,
  output logic                       result_a_valid_q,
  output logic                       result_b_valid_q,
  output logic                       conv_int_flag,
  output logic                       busy
);

  adsq_state_e           state_q;
  logic [CNT_W-1:0]      cnt_q;
  logic [ACQ_W-1:0]      acq_q;
  logic                  pair_q;
  logic                  pend_q;
  logic                  div_q;
  logic                  any_trig;
  logic                  hold_end;
  logic                  gap_end;
  logic                  delay_end;
  logic                  go_on;
  logic                  capture_stb;
  logic [FLAG_DELAY-1:0] flag_sr_q;
  logic                  last_result;

  logic [DATA_WIDTH-1:0] pipe_a_q [PIPE_DEPTH];
  logic [DATA_WIDTH-1:0] pipe_b_q [PIPE_DEPTH];
  logic [PIPE_DEPTH-1:0] pipe_v_q;
  logic [PIPE_DEPTH-1:0] pipe_p_q;

  function automatic logic [CNT_W-1:0] hold_ticks(input logic [ACQ_W-1:0] acq);
    hold_ticks = CNT_W'((32'(acq) + 1) * CONV_DIV - 1);
  endfunction

  function automatic logic [CNT_W-1:0] gap_ticks(input logic pair);
    gap_ticks = pair ? CNT_W'(GAP_PAIR_CLKS * CONV_DIV - 1)
                     : CNT_W'(GAP_SEQ_CLKS * CONV_DIV - 1);
  endfunction

  assign any_trig    = pulse_width_module_trigger | software_trigger |
                       external_conversion_trigger;
  assign delay_end   = (state_q == ADSQ_DELAY) && (cnt_q == '0);
  assign hold_end    = (state_q == ADSQ_HOLD) && (cnt_q == '0);
  assign gap_end     = (state_q == ADSQ_GAP) && (cnt_q == '0);
  assign go_on       = continuous_run | pend_q | any_trig;
  assign capture_stb = hold_end;
  assign busy        = (state_q != ADSQ_IDLE);
  assign sample_hold_pulse = (state_q == ADSQ_HOLD);

  // The converter clock is a plain divider output; all timing runs on sys_clk ticks.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      div_q <= 1'b0;
    end else begin
      div_q <= ~div_q;
    end
  end
  assign converter_clock = div_q;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_q <= ADSQ_IDLE;
      cnt_q   <= '0;
    end else begin
      case (state_q)
        ADSQ_IDLE: begin
          if (any_trig) begin
            state_q <= ADSQ_DELAY;
            cnt_q   <= CNT_W'(SH_DELAY_TICKS - 2);
          end
        end
        ADSQ_DELAY: begin
          if (delay_end) begin
            state_q <= ADSQ_HOLD;
            cnt_q   <= hold_ticks(acq_q);
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        ADSQ_HOLD: begin
          if (hold_end) begin
            state_q <= go_on ? ADSQ_GAP : ADSQ_IDLE;
            cnt_q   <= gap_ticks(pair_q);
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        ADSQ_GAP: begin
          if (gap_end) begin
            state_q <= ADSQ_HOLD;
            cnt_q   <= hold_ticks(acq_q);
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        default: begin
          state_q <= ADSQ_IDLE;
          cnt_q   <= '0;
        end
      endcase
    end
  end

  // A trigger seen while busy waits here; at the hold end the consuming clear wins over a new one.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pend_q <= 1'b0;
    end else if (busy && any_trig && !hold_end) begin
      pend_q <= 1'b1;
    end else if (hold_end) begin
      pend_q <= 1'b0;
    end
  end

  // Mode, window and channel are loaded at each sequence start and each hold end so a running pulse stays whole.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      acq_q    <= ACQ_RESET;
      pair_q   <= 1'b0;
      chan_a_q <= CHAN_RESET;
      chan_b_q <= CHAN_RESET;
    end else if ((state_q == ADSQ_IDLE && any_trig) || hold_end) begin
      acq_q  <= converter_control_one[ACQ_LSB +: ACQ_W];
      pair_q <= sample_pairing_select;
      if (sample_pairing_select) begin
        chan_a_q <= {1'b0, chan_select[2:0]};
        chan_b_q <= {1'b1, chan_select[2:0]};
      end else begin
        chan_a_q <= chan_select;
        chan_b_q <= chan_select;
      end
    end
  end

  // Result pipeline; stage 0 is loaded at the hold falling edge.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pipe_v_q <= '0;
      pipe_p_q <= '0;
    end else begin
      pipe_v_q <= {pipe_v_q[PIPE_DEPTH-2:0], capture_stb};
      pipe_p_q <= {pipe_p_q[PIPE_DEPTH-2:0], capture_stb & pair_q};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      for (int i = 0; i < PIPE_DEPTH; i++) begin
        pipe_a_q[i] <= DATA_WIDTH'(DATA_RESET);
        pipe_b_q[i] <= DATA_WIDTH'(DATA_RESET);
      end
    end else begin
      if (capture_stb) begin
        pipe_a_q[0] <= analog_a_value;
        pipe_b_q[0] <= analog_b_value;
      end
      for (int i = 1; i < PIPE_DEPTH; i++) begin
        pipe_a_q[i] <= pipe_a_q[i-1];
        pipe_b_q[i] <= pipe_b_q[i-1];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      result_a_q       <= DATA_WIDTH'(DATA_RESET);
      result_b_q       <= DATA_WIDTH'(DATA_RESET);
      result_a_valid_q <= 1'b0;
      result_b_valid_q <= 1'b0;
    end else begin
      result_a_valid_q <= pipe_v_q[RES_A_TAP];
      result_b_valid_q <= pipe_p_q[RES_B_TAP];
      if (pipe_v_q[RES_A_TAP]) begin
        result_a_q <= pipe_a_q[RES_A_TAP];
      end
      if (pipe_p_q[RES_B_TAP]) begin
        result_b_q <= pipe_b_q[RES_B_TAP];
      end
    end
  end

  // The flag follows the last result of a sample: B in pairing mode, A otherwise.
  assign last_result = result_b_valid_q | (result_a_valid_q & ~pipe_p_q[RES_A_TAP + 1]);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      flag_sr_q <= '0;
    end else begin
      flag_sr_q <= {flag_sr_q[FLAG_DELAY-2:0], last_result};
    end
  end
  assign conv_int_flag = flag_sr_q[FLAG_DELAY-1];

  a_trig_to_sample: assert property (@(posedge sys_clk) disable iff (rst)
    (state_q == ADSQ_IDLE && any_trig) |-> ##5 $rose(sample_hold_pulse))
    else $error("hold pulse did not start 2.5 converter clocks after trigger");

  a_hold_min_width: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(sample_hold_pulse) |-> sample_hold_pulse[*2])
    else $error("hold pulse shorter than one converter clock");

  a_hold_zero_acq: assert property (@(posedge sys_clk) disable iff (rst)
    ($rose(sample_hold_pulse) && acq_q == 4'h0) |-> ##2 !sample_hold_pulse)
    else $error("hold pulse with zero window not one converter clock");

  a_result_a_lat: assert property (@(posedge sys_clk) disable iff (rst)
    capture_stb |-> ##9 result_a_valid_q)
    else $error("group A result not four converter clocks after sampling");

  a_result_b_lat: assert property (@(posedge sys_clk) disable iff (rst)
    (capture_stb && pair_q) |-> ##11 result_b_valid_q)
    else $error("group B result not five converter clocks after sampling");

  a_pair_channels: assert property (@(posedge sys_clk) disable iff (rst)
    (sample_hold_pulse && pair_q) |-> (chan_b_q == {1'b1, chan_a_q[2:0]} && !chan_a_q[3]))
    else $error("pair channels not matched A/B index");

  a_flag_after_res: assert property (@(posedge sys_clk) disable iff (rst)
    conv_int_flag |-> $past(result_a_valid_q, 2) || $past(result_b_valid_q, 2))
    else $error("interrupt flag without preceding result update");

  a_trig_held: assert property (@(posedge sys_clk) disable iff (rst)
    (busy && any_trig) |=> (pend_q || state_q == ADSQ_GAP))
    else $error("trigger during busy sequence was lost");

  a_pair_spacing: assert property (@(posedge sys_clk) disable iff (rst)
    (capture_stb && pair_q && continuous_run && acq_q == 4'h0) |-> ##6 capture_stb)
    else $error("pair samples not three converter clocks apart");

endmodule

// ===== sim/adsq_analog_src.sv
// Partner model standing in for the analog channel pair ahead of the converter.
`timescale 1ns/10ps
module adsq_analog_src
  import adsq_pkg::*;
(
  input  wire logic         sys_clk,
  input  wire logic         rst,
  output logic [DATA_W-1:0] analog_a_value,
  output logic [DATA_W-1:0] analog_b_value
);
  // Both inputs move every cycle, so a capture taken one cycle off gives a wrong result.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      analog_a_value <= 12'h5a3;
      analog_b_value <= 12'h0c6;
    end else begin
      analog_a_value <= analog_a_value + 12'h137;
      analog_b_value <= analog_b_value - 12'h29b;
    end
  end
endmodule

// ===== sim/testbench.sv
// Self-checking bench for the dual-sample conversion sequencer.
`timescale 1ns/10ps
`define check_eq(nm, exp, got) begin compares++; if ((got) !== (exp)) begin failures++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, exp, got); end end
module testbench
  import adsq_pkg::*;
;
  typedef struct {logic pr; logic [DATA_W-1:0] a; logic [DATA_W-1:0] b; int c;} adsq_note_s;
  logic              sys_clk;
  logic              rst;
  logic              sample_pairing_select;
  logic              continuous_run;
  logic [15:0]       converter_control_one;
  logic [CHAN_W-1:0] chan_select;
  logic [2:0]        trig;
  logic [DATA_W-1:0] analog_a_value;
  logic [DATA_W-1:0] analog_b_value;
  logic              sample_hold_pulse;
  logic [CHAN_W-1:0] chan_a_q;
  logic [CHAN_W-1:0] chan_b_q;
  logic [DATA_W-1:0] result_a_q;
  logic [DATA_W-1:0] result_b_q;
  logic              result_a_valid_q;
  logic              result_b_valid_q;
  logic              conv_int_flag;
  logic              busy;
  logic              converter_clock;
  logic              conv_clk_exp;
  int                cyc = 0;
  int                failures = 0;
  int                compares = 0;
  adsq_note_s        q[$];

  adsq_analog_src u_adsq_analog_src (.sys_clk, .rst, .analog_a_value, .analog_b_value);
  adsq_sequencer u_adsq_sequencer (
    .sys_clk, .rst, .sample_pairing_select, .converter_control_one, .chan_select,
    .continuous_run, .pulse_width_module_trigger(trig[0]), .software_trigger(trig[1]),
    .external_conversion_trigger(trig[2]), .analog_a_value, .analog_b_value,
    .converter_clock, .sample_hold_pulse, .chan_a_q, .chan_b_q, .result_a_q, .result_b_q,
    .result_a_valid_q, .result_b_valid_q, .conv_int_flag, .busy
  );

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // The converter clock is expected low through reset and to toggle on every rising sys_clk edge after it.
  always @(posedge sys_clk) conv_clk_exp <= rst ? 1'b0 : ~conv_clk_exp;

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc >= 4000) begin
      failures++;
      complete_run();
    end
  end

  // One conversion sequence of n hold pulses; th > 1 repeats the trigger while busy.
  task automatic conv(input logic pr, input logic [3:0] acq, input logic [3:0] sel,
                      input int src, input int n, input int th);
    logic [15:0]       ctl;
    logic [DATA_W-1:0] ea;
    logic [DATA_W-1:0] eb;
    int                w;
    int                lastc;
    int                gap;
    ctl = 16'($urandom);
    ctl[11:8] = acq;
    gap = pr ? (3 + acq) * 2 : (2 + acq) * 2;
    @(posedge sys_clk);
    sample_pairing_select <= pr;
    converter_control_one <= ctl;
    chan_select <= sel;
    continuous_run <= (n > 1 && th == 1);
    trig[src] <= 1'b1;
    @(negedge sys_clk);
    lastc = cyc;
    repeat (th) @(posedge sys_clk);
    trig <= 3'h0;
    for (int k = 0; k < n; k++) begin
      w = 0;
      do begin
        @(negedge sys_clk);
        w++;
      end while (sample_hold_pulse !== 1'b1 && w < 60);
      `check_eq("hold_start", k == 0 ? 5 : gap - 2 * acq - 1, cyc - lastc)
      `check_eq("chan_a", pr ? {1'b0, sel[2:0]} : sel, chan_a_q)
      `check_eq("chan_b", pr ? {1'b1, sel[2:0]} : sel, chan_b_q)
      `check_eq("busy_on", 1'b1, busy)
      w = 0;
      while (sample_hold_pulse === 1'b1 && w < 40) begin
        ea = analog_a_value;
        eb = analog_b_value;
        lastc = cyc;
        w++;
        @(negedge sys_clk);
      end
      `check_eq("hold_width", (1 + acq) * 2, w)
      q.push_back('{pr, ea, eb, lastc});
      if (k == n - 2 && th == 1) @(posedge sys_clk) continuous_run <= 1'b0;
    end
    w = 0;
    repeat (24) begin
      @(negedge sys_clk);
      if (sample_hold_pulse === 1'b1) w++;
    end
    `check_eq("extra_hold", 0, w)
    `check_eq("busy", 1'b0, busy)
  endtask

  always @(negedge sys_clk) begin
    if (rst === 1'b0) `check_eq("converter_clock", conv_clk_exp, converter_clock)
    if (!rst && (result_a_valid_q | result_b_valid_q | conv_int_flag) === 1'b1) begin
      if (q.size() == 0) `check_eq("note", 1, 0)
      else begin
        if (result_a_valid_q === 1'b1) begin
          `check_eq("result_a", q[0].a, result_a_q)
          `check_eq("a_time", q[0].c + 9, cyc)
        end
        if (result_b_valid_q === 1'b1) begin
          `check_eq("result_b", q[0].b, result_b_q)
          `check_eq("b_time", {1'b1, q[0].c + 11}, {q[0].pr, cyc})
        end
        if (conv_int_flag === 1'b1) begin
          `check_eq("flag_time", q[0].c + (q[0].pr ? 13 : 11), cyc)
          void'(q.pop_front());
        end
      end
    end
  end

  initial begin
    void'($urandom(32'h098a24be));
    rst = 1'b1;
    sample_pairing_select = 1'b0;
    continuous_run = 1'b0;
    converter_control_one = 16'h0000;
    chan_select = 4'h0;
    trig = 3'h0;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    for (int s = 0; s < 3; s++) conv(1'b1, 4'h0, 4'($urandom), s, 1, 1);
    conv(1'b1, 4'hf, 4'h7, 1, 3, 1);
    conv(1'b1, 4'h0, 4'h5, 0, 2, 1);
    conv(1'b1, 4'h2, 4'h8, 2, 2, 3);
    conv(1'b0, 4'h1, 4'hf, 0, 2, 1);
    conv(1'b0, 4'h0, 4'h9, 1, 2, 3);
    for (int i = 0; i < 4; i++) conv(1'($urandom), 4'($urandom), 4'($urandom), i % 3, 1 + i % 2, 1);
    `check_eq("notes_left", 0, q.size())
    complete_run();
  end
endmodule
